// *** debug_pkg.sv ***
// shared constants and carriers of the single-wire background debug controller
package debug_pkg;

   // serial bit timing, in clock cycles after the perceived bit start
   localparam int unsigned BIT_CYCLES      = 16;
   localparam int unsigned RX_SAMPLE_CYCLE = 10;
   localparam int unsigned ONE_PULSE_CYCLE = 7;
   localparam int unsigned ZERO_LOW_CYCLES = 13;
   localparam int unsigned TIMEOUT_CYCLES  = 512;

   // longest wait for a cpu dead cycle before a cycle is stolen
   localparam int unsigned STEAL_WAIT_CYCLES = 128;

   // frame field sizes
   localparam int unsigned OPCODE_BITS = 8;
   localparam int unsigned WORD_BITS   = 16;

   // hardware command opcodes
   localparam logic [7:0] OP_BACKGROUND  = 8'h90;
   localparam logic [7:0] OP_READ_BYTE_M = 8'he4;
   localparam logic [7:0] OP_READ_BYTE_U = 8'he0;
   localparam logic [7:0] OP_READ_WORD_M = 8'hec;
   localparam logic [7:0] OP_READ_WORD_U = 8'he8;
   localparam logic [7:0] OP_WRITE_BYTE_M = 8'hc4;
   localparam logic [7:0] OP_WRITE_BYTE_U = 8'hc0;
   localparam logic [7:0] OP_WRITE_WORD_M = 8'hcc;
   localparam logic [7:0] OP_WRITE_WORD_U = 8'hc8;

   // opcode field positions of hardware read/write commands
   localparam int unsigned OPF_MAP  = 2;
   localparam int unsigned OPF_WORD = 3;
   localparam int unsigned OPF_READ = 5;

   // debug resources in the top of the address space
   localparam logic [15:0] STATUS_ADDR  = 16'hff01;
   localparam logic [15:0] DBG_REG_LO   = 16'hff00;
   localparam logic [15:0] DBG_REG_HI   = 16'hff06;
   localparam logic [15:0] DBG_ROM_LO   = 16'hff20;
   localparam logic [15:0] DBG_ROM_HI   = 16'hffff;

   // status byte layout and reset value
   localparam int unsigned ST_ENABLE_BIT = 7;
   localparam int unsigned ST_ACTIVE_BIT = 6;
   localparam logic [7:0]  STATUS_RESET  = 8'h00;

   // one memory access issued by a hardware command
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        write;
      logic        word;
      logic        map_debug;
   } mem_cmd_t;

   // command sequencer states, gray along the write command path
   typedef enum logic [2:0] {
      ST_OPCODE = 3'b000,
      ST_ADDR   = 3'b001,
      ST_WDATA  = 3'b011,
      ST_ACCESS = 3'b010,
      ST_RDATA  = 3'b110
   } cmd_state_t;

endpackage

// *** wire_bit_engine.sv ***
// bit-level timing of the single debug wire: edge detect, sampling, driving, timeout
`timescale 1ns/100ps
module wire_bit_engine #(
   parameter int unsigned TIMEOUT = debug_pkg::TIMEOUT_CYCLES
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // debug wire pin
   input  wire logic pin_in,
   output logic      pin_out,
   output logic      pin_oe,
   // bit stream to and from the sequencer
   input  wire logic tx_en,
   input  wire logic tx_bit,
   output logic      bit_start,
   output logic      rx_valid,
   output logic      rx_bit,
   output logic      timeout
);
   import debug_pkg::*;

   localparam int unsigned IDLE_W = $clog2(TIMEOUT + 1);

   logic [1:0]        sync_r;
   logic              level_r;
   logic              fall;
   logic [4:0]        cnt_r;
   logic [4:0]        cnt_nxt;
   logic              tx_mode_r;
   logic              tx_val_r;
   logic [IDLE_W-1:0] idle_r;
   logic              expired_r;

   if (TIMEOUT < BIT_CYCLES) $error("wire_bit_engine: TIMEOUT shorter than a bit time");

   // two-stage synchroniser, then edge history
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sync_r  <= 2'b11;
         level_r <= 1'b1;
      end else begin
         sync_r  <= {sync_r[0], pin_in};
         level_r <= sync_r[1];
      end
   end

   assign fall      = level_r & ~sync_r[1];
   assign bit_start = fall;

   // cycles since perceived bit start, saturating
   always_comb begin
      cnt_nxt = cnt_r;
      if (fall) begin
         cnt_nxt = 5'h01;
      end else if (cnt_r != 5'h1f && cnt_r != 5'h00) begin
         cnt_nxt = cnt_r + 5'h01;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt_r     <= 5'h00;
         tx_mode_r <= 1'b0;
         tx_val_r  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         if (fall) begin
            tx_mode_r <= tx_en;
            tx_val_r  <= tx_bit;
         end
      end
   end

   // host-to-target sample point
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rx_valid <= 1'b0;
         rx_bit   <= 1'b0;
      end else begin
         rx_valid <= ~tx_mode_r & ~fall & (cnt_r == 5'(RX_SAMPLE_CYCLE));
         if (~tx_mode_r & (cnt_r == 5'(RX_SAMPLE_CYCLE))) begin
            rx_bit <= sync_r[1];
         end
      end
   end

   // target-to-host drive: low phase for a zero, speed-up pulse for both
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pin_oe  <= 1'b0;
         pin_out <= 1'b1;
      end else begin
         pin_oe  <= 1'b0;
         pin_out <= 1'b1;
         if (fall ? tx_en : tx_mode_r) begin
            if (!(fall ? tx_bit : tx_val_r)) begin
               if (cnt_nxt >= 5'h01 && cnt_nxt <= 5'(ZERO_LOW_CYCLES)) begin
                  pin_oe  <= 1'b1;
                  pin_out <= 1'b0;
               end else if (cnt_nxt == 5'(ZERO_LOW_CYCLES + 1)) begin
                  pin_oe <= 1'b1;
               end
            end else if (cnt_nxt == 5'(ONE_PULSE_CYCLE)) begin
               pin_oe <= 1'b1;
            end
         end
      end
   end

   // idle link watchdog between host falling edges
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         idle_r    <= '0;
         expired_r <= 1'b1;
         timeout   <= 1'b0;
      end else begin
         timeout <= 1'b0;
         if (fall) begin
            idle_r    <= '0;
            expired_r <= 1'b0;
         end else if (!expired_r) begin
            idle_r <= idle_r + IDLE_W'(1);
            if (idle_r == IDLE_W'(TIMEOUT - 1)) begin
               expired_r <= 1'b1;
               timeout   <= 1'b1;
            end
         end
      end
   end

endmodule

// *** background_debug_controller.sv ***
// background debug controller: serial command sequencer, status and debug map
`timescale 1ns/100ps
module background_debug_controller #(
   parameter int unsigned TIMEOUT    = debug_pkg::TIMEOUT_CYCLES,
   parameter int unsigned STEAL_WAIT = debug_pkg::STEAL_WAIT_CYCLES
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              resetn,
   // debug wire pin
   input  wire logic              debug_wire_pin_in,
   output logic                   debug_wire_pin_out,
   output logic                   debug_wire_pin_oe,
   // operating mode strap
   input  wire logic              special_single_chip,
   // cpu execution handshake
   input  wire logic              instr_boundary,
   input  wire logic              tag_hit,
   input  wire logic              cpu_background_instruction,
   input  wire logic              firmware_go,
   input  wire logic              dead_cycle,
   output logic                   background_active,
   output logic                   background_resume,
   output logic                   cpu_freeze,
   output logic                   peripheral_suspend,
   // firmware command hand-off
   output logic                   fw_cmd_valid,
   output logic [7:0]             fw_opcode,
   // cpu address map decode
   input  wire logic [15:0]       cpu_addr,
   output logic                   debug_reg_sel,
   output logic                   debug_rom_sel,
   // memory access port
   output logic                   mem_req,
   output debug_pkg::mem_cmd_t    mem_cmd,
   input  wire logic              mem_ack,
   input  wire logic [15:0]       mem_rdata,
   // status
   output logic                   firmware_enable_flag,
   output logic                   background_active_flag
);
   import debug_pkg::*;

   localparam int unsigned STEAL_W = $clog2(STEAL_WAIT + 1);

   if (STEAL_WAIT < 1) $error("background_debug_controller: STEAL_WAIT must be positive");

   logic               bit_start;
   logic               rx_valid;
   logic               rx_bit;
   logic               timeout;
   cmd_state_t         state_r;
   logic [15:0]        shift_r;
   logic [4:0]         nbits_r;
   logic [7:0]         opcode_r;
   logic [15:0]        addr_r;
   logic               enable_r;
   logic               active_r;
   logic               bg_pend_r;
   logic               init_done_r;
   logic [STEAL_W-1:0] wait_r;
   logic               mem_first_r;
   logic               stealing_r;
   logic [15:0]        shift_in;
   logic               op_read;
   logic               op_hw_rw;
   logic               status_hit;
   logic               bg_cmd;
   logic               status_write;
   logic [7:0]         status_byte;

   wire_bit_engine #(
      .TIMEOUT   (TIMEOUT)
   ) u_wire (
      .clock     (clock),
      .resetn    (resetn),
      .pin_in    (debug_wire_pin_in),
      .pin_out   (debug_wire_pin_out),
      .pin_oe    (debug_wire_pin_oe),
      .tx_en     (state_r == ST_RDATA),
      .tx_bit    (shift_r[15]),
      .bit_start (bit_start),
      .rx_valid  (rx_valid),
      .rx_bit    (rx_bit),
      .timeout   (timeout)
   );

   // opcode classes and the status byte
   assign shift_in = {shift_r[14:0], rx_bit};
   assign op_hw_rw = (shift_in[7:0] == OP_READ_BYTE_M) || (shift_in[7:0] == OP_READ_BYTE_U) ||
                     (shift_in[7:0] == OP_READ_WORD_M) || (shift_in[7:0] == OP_READ_WORD_U) ||
                     (shift_in[7:0] == OP_WRITE_BYTE_M) || (shift_in[7:0] == OP_WRITE_BYTE_U) ||
                     (shift_in[7:0] == OP_WRITE_WORD_M) || (shift_in[7:0] == OP_WRITE_WORD_U);
   assign op_read    = opcode_r[OPF_READ];
   assign status_hit = opcode_r[OPF_MAP] & ~opcode_r[OPF_WORD] & (addr_r == STATUS_ADDR);
   assign status_byte = {enable_r, active_r, 6'h00};

   assign bg_cmd = (state_r == ST_OPCODE) && rx_valid && (nbits_r == 5'(OPCODE_BITS - 1)) &&
                   (shift_in[7:0] == OP_BACKGROUND);
   assign status_write = (state_r == ST_ACCESS) && !op_read && status_hit;

   // serial command sequencer
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r      <= ST_OPCODE;
         shift_r      <= 16'h0000;
         nbits_r      <= 5'h00;
         opcode_r     <= 8'h00;
         addr_r       <= 16'h0000;
         fw_cmd_valid <= 1'b0;
         fw_opcode    <= 8'h00;
      end else if (timeout) begin
         state_r  <= ST_OPCODE;
         nbits_r  <= 5'h00;
         opcode_r <= 8'h00;
         fw_cmd_valid <= 1'b0;
      end else begin
         fw_cmd_valid <= 1'b0;
         case (state_r)
            ST_OPCODE: begin
               if (rx_valid) begin
                  shift_r <= shift_in;
                  nbits_r <= nbits_r + 5'h01;
                  if (nbits_r == 5'(OPCODE_BITS - 1)) begin
                     nbits_r  <= 5'h00;
                     opcode_r <= shift_in[7:0];
                     if (op_hw_rw) begin
                        state_r <= ST_ADDR;
                     end else if (shift_in[7:0] != OP_BACKGROUND && active_r) begin
                        fw_cmd_valid <= 1'b1;
                        fw_opcode    <= shift_in[7:0];
                     end
                  end
               end
            end
            ST_ADDR: begin
               if (rx_valid) begin
                  shift_r <= shift_in;
                  nbits_r <= nbits_r + 5'h01;
                  if (nbits_r == 5'(WORD_BITS - 1)) begin
                     nbits_r <= 5'h00;
                     addr_r  <= shift_in;
                     state_r <= op_read ? ST_ACCESS : ST_WDATA;
                  end
               end
            end
            ST_WDATA: begin
               if (rx_valid) begin
                  shift_r <= shift_in;
                  nbits_r <= nbits_r + 5'h01;
                  if (nbits_r == 5'(WORD_BITS - 1)) begin
                     nbits_r <= 5'h00;
                     state_r <= ST_ACCESS;
                  end
               end
            end
            ST_ACCESS: begin
               if (status_hit) begin
                  // status byte is served here, not by memory
                  state_r <= op_read ? ST_RDATA : ST_OPCODE;
                  shift_r <= op_read ? {8'h00, status_byte} : shift_r;
               end else if (mem_ack) begin
                  state_r <= op_read ? ST_RDATA : ST_OPCODE;
                  if (op_read) begin
                     if (opcode_r[OPF_WORD]) begin
                        shift_r <= mem_rdata;
                     end else if (addr_r[0]) begin
                        shift_r <= {8'h00, mem_rdata[7:0]};
                     end else begin
                        shift_r <= {mem_rdata[7:0], 8'h00};
                     end
                  end
               end
            end
            ST_RDATA: begin
               if (bit_start) begin
                  shift_r <= {shift_r[14:0], 1'b0};
                  nbits_r <= nbits_r + 5'h01;
                  if (nbits_r == 5'(WORD_BITS - 1)) begin
                     nbits_r <= 5'h00;
                     state_r <= ST_OPCODE;
                  end
               end
            end
            default: begin
               state_r <= ST_OPCODE;
            end
         endcase
      end
   end

   // memory access: dead cycles first, steal when waited too long
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mem_req     <= 1'b0;
         mem_cmd     <= '0;
         wait_r      <= '0;
         mem_first_r <= 1'b0;
         stealing_r  <= 1'b0;
      end else begin
         mem_first_r <= 1'b0;
         if (mem_req) begin
            if (mem_ack || timeout) begin
               mem_req    <= 1'b0;
               stealing_r <= 1'b0;
            end
         end else if (state_r == ST_ACCESS && !status_hit && !timeout) begin
            if (dead_cycle || wait_r == STEAL_W'(STEAL_WAIT)) begin
               mem_req           <= 1'b1;
               mem_first_r       <= 1'b1;
               stealing_r        <= ~dead_cycle;
               wait_r            <= '0;
               mem_cmd.addr      <= addr_r;
               mem_cmd.write     <= ~op_read;
               mem_cmd.word      <= opcode_r[OPF_WORD];
               mem_cmd.map_debug <= opcode_r[OPF_MAP] & active_r;
               if (opcode_r[OPF_WORD] || !addr_r[0]) begin
                  mem_cmd.wdata <= opcode_r[OPF_WORD] ? shift_r : {8'h00, shift_r[15:8]};
               end else begin
                  mem_cmd.wdata <= {8'h00, shift_r[7:0]};
               end
            end else begin
               wait_r <= wait_r + STEAL_W'(1);
            end
         end else begin
            wait_r <= '0;
         end
      end
   end

   // cpu held off while a stolen or multi-cycle access is open
   assign cpu_freeze = mem_req & (stealing_r | ~mem_first_r);

   // firmware enable flag, loaded from the strap after reset, then written only through the status byte
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         enable_r <= STATUS_RESET[ST_ENABLE_BIT];
      end else if (!init_done_r) begin
         enable_r <= special_single_chip;
      end else if (status_write && !active_r) begin
         enable_r <= addr_r[0] ? shift_r[ST_ENABLE_BIT] : shift_r[8 + ST_ENABLE_BIT];
      end
   end

   // activation requests and the active flag
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         active_r          <= STATUS_RESET[ST_ACTIVE_BIT];
         bg_pend_r         <= 1'b0;
         init_done_r       <= 1'b0;
         background_resume <= 1'b0;
      end else begin
         init_done_r       <= 1'b1;
         background_resume <= 1'b0;
         if (!init_done_r) begin
            active_r <= special_single_chip;
         end else if (active_r) begin
            bg_pend_r <= 1'b0;
            if (firmware_go) begin
               active_r <= 1'b0;
            end
         end else if (enable_r && tag_hit) begin
            active_r <= 1'b1;
         end else if (enable_r && (cpu_background_instruction ||
                                   (instr_boundary && (bg_pend_r || bg_cmd)))) begin
            active_r  <= 1'b1;
            bg_pend_r <= 1'b0;
         end else begin
            if (bg_cmd && enable_r) begin
               bg_pend_r <= 1'b1;
            end
            if (!enable_r && (cpu_background_instruction || tag_hit)) begin
               background_resume <= 1'b1;
            end
         end
      end
   end

   assign background_active      = active_r;
   assign background_active_flag = active_r;
   assign firmware_enable_flag   = enable_r;
   assign peripheral_suspend     = active_r;

   // debug registers and rom exist only while active
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         debug_reg_sel <= 1'b0;
         debug_rom_sel <= 1'b0;
      end else begin
         debug_reg_sel <= active_r && cpu_addr >= DBG_REG_LO && cpu_addr <= DBG_REG_HI;
         debug_rom_sel <= active_r && cpu_addr >= DBG_ROM_LO && cpu_addr <= DBG_ROM_HI;
      end
   end

endmodule

// *** bgdbg_asserts.sv ***
// port checks of the background debug controller
`timescale 1ns/100ps
module bgdbg_checker #(
   parameter int unsigned TIMEOUT    = 512,
   parameter int unsigned STEAL_WAIT = 128
) (
   input wire logic                clock,
   input wire logic                resetn,
   input wire logic                debug_wire_pin_out,
   input wire logic                debug_wire_pin_oe,
   input wire logic                tag_hit,
   input wire logic                cpu_background_instruction,
   input wire logic                background_active,
   input wire logic                background_resume,
   input wire logic                cpu_freeze,
   input wire logic                peripheral_suspend,
   input wire logic [15:0]         cpu_addr,
   input wire logic                debug_reg_sel,
   input wire logic                debug_rom_sel,
   input wire logic                mem_req,
   input wire debug_pkg::mem_cmd_t mem_cmd,
   input wire logic                mem_ack,
   input wire logic                firmware_enable_flag,
   input wire logic                background_active_flag
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence s_low13;
      (debug_wire_pin_oe && !debug_wire_pin_out)[*8] ##1
      (debug_wire_pin_oe && !debug_wire_pin_out)[*5];
   endsequence
   sequence s_kick;
      (debug_wire_pin_oe && debug_wire_pin_out) ##1 !debug_wire_pin_oe;
   endsequence
   property p_zero;
      $rose(debug_wire_pin_oe) && !debug_wire_pin_out |-> s_low13 ##1 s_kick;
   endproperty
   a_zero: assert property (p_zero) else $error("zero bit drive wrong");
   property p_one;
      $rose(debug_wire_pin_oe) && debug_wire_pin_out |=> !debug_wire_pin_oe;
   endproperty
   a_one: assert property (p_one) else $error("one bit pulse wrong");
   property p_resume;
      tag_hit && !firmware_enable_flag |=> background_resume && !background_active_flag;
   endproperty
   a_resume: assert property (p_resume) else $error("refused activation wrong");
   property p_enter;
      (tag_hit || cpu_background_instruction) && firmware_enable_flag |=> background_active_flag;
   endproperty
   a_enter: assert property (p_enter) else $error("activation missed");
   property p_needs_en;
      $rose(background_active_flag) |-> firmware_enable_flag;
   endproperty
   a_needs_en: assert property (p_needs_en) else $error("active without enable");
   property p_susp;
      peripheral_suspend == background_active_flag && background_active == background_active_flag;
   endproperty
   a_susp: assert property (p_susp) else $error("suspend not tracking active");
   property p_reg;
      debug_reg_sel |-> $past(cpu_addr) inside {[16'hff00:16'hff06]} && $past(background_active_flag);
   endproperty
   a_reg: assert property (p_reg) else $error("register select wrong");
   property p_rom;
      cpu_addr >= 16'hff20 && background_active_flag |=> debug_rom_sel;
   endproperty
   a_rom: assert property (p_rom) else $error("rom select missing");
   property p_hold;
      mem_req && !mem_ack |=> mem_req && $stable(mem_cmd);
   endproperty
   a_hold: assert property (p_hold) else $error("access not held");
   property p_drop;
      mem_req && mem_ack |=> !mem_req;
   endproperty
   a_drop: assert property (p_drop) else $error("access not closed");
   property p_freeze;
      (cpu_freeze |-> mem_req) and (mem_req && $past(mem_req) |-> cpu_freeze);
   endproperty
   a_freeze: assert property (p_freeze) else $error("freeze wrong");
endmodule

bind background_debug_controller bgdbg_checker #(.TIMEOUT(TIMEOUT), .STEAL_WAIT(STEAL_WAIT)) u_chk (
   .clock, .resetn, .debug_wire_pin_out, .debug_wire_pin_oe, .tag_hit,
   .cpu_background_instruction, .background_active, .background_resume, .cpu_freeze,
   .peripheral_suspend, .cpu_addr, .debug_reg_sel, .debug_rom_sel, .mem_req, .mem_cmd,
   .mem_ack, .firmware_enable_flag, .background_active_flag);

// *** host_model.sv ***
// behavioural host driving the single debug wire
`timescale 1ns/100ps
module host_model (
   // clock and resolved wire
   input wire logic clock,
   input wire logic wire_level,
   // high while the host pulls the wire low
   output logic     host_low
);
   initial host_low = 1'b0;
   // twenty-one cycles a bit; released wire floats high
   task automatic put(input logic b);
      @(posedge clock) host_low <= 1'b1;
      repeat (b ? 2 : 14) @(posedge clock);
      host_low <= 1'b0;
      repeat (b ? 18 : 6) @(posedge clock);
   endtask
   task automatic get(output logic b);
      @(posedge clock) host_low <= 1'b1;
      // held until the target already pulls a zero low
      repeat (4) @(posedge clock);
      host_low <= 1'b0;
      repeat (6) @(posedge clock);
      #1 b = wire_level;
      repeat (9) @(posedge clock);
   endtask
   task automatic op8(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) put(v[i]);
   endtask
   task automatic word(input logic [15:0] v);
      for (int i = 15; i >= 0; i--) put(v[i]);
   endtask
   task automatic rdword(output logic [15:0] v);
      for (int i = 15; i >= 0; i--) get(v[i]);
   endtask
endmodule

// *** background_debug_controller_bench.sv ***
// self-checking bench of the background debug controller
`timescale 1ns/100ps
module background_debug_controller_bench;
   import debug_pkg::*;
   logic        clock, resetn, ssc, boundary, tag, bgi, go, dead, ack, pin_out, pin_oe;
   logic        active, req, fen, fact, reg_sel, rom_sel, host_low;
   logic [15:0] cpu_addr, rdata, got;
   logic [7:0]  fw_op;
   mem_cmd_t    cmd_bus, last_cmd;
   int          mismatches, comparisons;
   wire logic   wire_level = pin_oe ? pin_out : !host_low;

   background_debug_controller #(.STEAL_WAIT(4)) dut (
      .clock(clock), .resetn(resetn), .debug_wire_pin_in(wire_level),
      .debug_wire_pin_out(pin_out), .debug_wire_pin_oe(pin_oe), .special_single_chip(ssc),
      .instr_boundary(boundary), .tag_hit(tag), .cpu_background_instruction(bgi),
      .firmware_go(go), .dead_cycle(dead), .background_active(active),
      .background_resume(), .cpu_freeze(), .peripheral_suspend(), .fw_cmd_valid(),
      .fw_opcode(fw_op), .cpu_addr(cpu_addr), .debug_reg_sel(reg_sel), .debug_rom_sel(rom_sel),
      .mem_req(req), .mem_cmd(cmd_bus), .mem_ack(ack), .mem_rdata(rdata),
      .firmware_enable_flag(fen), .background_active_flag(fact));
   host_model host (.clock(clock), .wire_level(wire_level), .host_low(host_low));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // memory answers one cycle after each request
   always @(posedge clock) begin
      ack <= req && !ack;
      if (req && !ack) last_cmd <= cmd_bus;
   end

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic summarize();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // kind 0 no data, 1 read, 2 write
   task automatic cmd(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d,
                      input int kind);
      host.op8(op);
      if (kind != 0) host.word(a);
      if (kind == 1) begin
         repeat (150) @(posedge clock);
         host.rdword(got);
      end
      if (kind == 2) host.word(d);
      repeat (150) @(posedge clock);
   endtask
   task automatic pulse(input logic [3:0] m);
      @(posedge clock) {go, bgi, tag, boundary} <= m;
      @(posedge clock) {go, bgi, tag, boundary} <= 4'h0;
      repeat (2) @(posedge clock);
   endtask
   task automatic t_status();
      cmd(OP_READ_BYTE_M, STATUS_ADDR, 16'h0000, 1);
      chk(got, 16'h0000);
      pulse(4'h2);
      pulse(4'h4);
      chk({15'h0, fact}, 16'h0000);
      cmd(8'h10, 16'h0000, 16'h0000, 0);
      chk({8'h00, fw_op}, 16'h0000);
      $display("status and refusal done");
   endtask
   task automatic t_read();
      logic [7:0]  op [3] = '{OP_READ_BYTE_U, OP_READ_BYTE_U, OP_READ_WORD_M};
      logic [15:0] ad [3] = '{16'h1234, 16'h1235, 16'h2000};
      logic [15:0] ex [3] = '{16'h5a00, 16'h005a, 16'h005a};
      for (int i = 0; i < 3; i++) begin
         dead <= (i == 1);
         cmd(op[i], ad[i], 16'h0000, 1);
         chk(got, ex[i]);
         chk(last_cmd.addr, ad[i]);
      end
      $display("reads done");
   endtask
   task automatic t_write();
      cmd(OP_WRITE_BYTE_U, 16'h2001, 16'h00a5, 2);
      chk({last_cmd.write, last_cmd.wdata[7:0]}, 16'h01a5);
      cmd(OP_WRITE_BYTE_M, STATUS_ADDR, 16'h0080, 2);
      chk({15'h0, fen}, 16'h0001);
      cmd(OP_READ_BYTE_M, STATUS_ADDR, 16'h0000, 1);
      chk(got, 16'h0080);
      $display("writes done");
   endtask
   task automatic t_bg();
      cmd(OP_BACKGROUND, 16'h0000, 16'h0000, 0);
      chk({15'h0, fact}, 16'h0000);
      pulse(4'h1);
      chk({15'h0, fact}, 16'h0001);
      cmd(OP_READ_BYTE_M, STATUS_ADDR, 16'h0000, 1);
      chk(got, 16'h00c0);
      @(posedge clock) cpu_addr <= 16'hff03;
      repeat (2) @(posedge clock);
      chk({15'h0, reg_sel}, 16'h0001);
      pulse(4'h8);
      @(posedge clock) cpu_addr <= 16'hffff;
      repeat (2) @(posedge clock);
      chk({15'h0, rom_sel}, 16'h0000);
      pulse(4'h2);
      pulse(4'h8);
      pulse(4'h4);
      chk({15'h0, active}, 16'h0001);
      cmd(8'h08, 16'h0000, 16'h0000, 0);
      chk({8'h00, fw_op}, 16'h0008);
      pulse(4'h8);
      $display("background entry done");
   endtask
   task automatic t_timeout();
      for (int i = 7; i >= 4; i--) host.put(OP_READ_BYTE_M[i]);
      repeat (TIMEOUT_CYCLES + 20) @(posedge clock);
      cmd(OP_READ_BYTE_M, STATUS_ADDR, 16'h0000, 1);
      chk(got, 16'h0080);
      $display("timeout done");
   endtask
   task automatic t_strap();
      @(posedge clock) resetn <= 1'b0;
      ssc <= 1'b1;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      repeat (3) @(posedge clock);
      chk({14'h0, fen, fact}, 16'h0003);
      $display("strap reset done");
   endtask

   initial begin
      repeat (100000) @(posedge clock);
      mismatches++;
      summarize();
   end
   initial begin
      resetn = 1'b0;
      ssc = 1'b0;
      {go, bgi, tag, boundary} = 4'h0;
      dead = 1'b0;
      ack = 1'b0;
      cpu_addr = 16'h0000;
      rdata = 16'h005a;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      repeat (4) @(posedge clock);
      t_status();
      t_read();
      t_write();
      t_bg();
      t_timeout();
      t_strap();
      summarize();
   end
endmodule
